// file: src/cbm_pkg.sv
// Types shared by the core bus matrix router.
// No assumptions beyond SystemVerilog packages.
package cbm_pkg;
  typedef enum logic [1:0] {
    CBM_TGT_AHB,
    CBM_TGT_SCIO,
    CBM_TGT_PPB,
    CBM_TGT_NONE
  } cbm_tgt_t;

  typedef enum logic {
    CBM_MST_CORE,
    CBM_MST_DBG
  } cbm_mst_t;
endpackage

// file: src/cbm_regs.svh
// Address map constants for the core bus matrix router.
// Assumes 32-bit byte addresses; included by the router only.
`ifndef CBM_REGS_SVH
`define CBM_REGS_SVH

`define CBM_SCIO_BASE     32'hd0000000
`define CBM_SCIO_LAST     32'hdfffffff
`define CBM_PPB_BASE      32'he0000000
`define CBM_PPB_LAST      32'hefffffff
`define CBM_CODE0_LAST    32'h3fffffff
`define CBM_CODE1_BASE    32'h60000000
`define CBM_CODE1_LAST    32'h9fffffff
`define CBM_DEV0_BASE     32'h40000000
`define CBM_DEV0_LAST     32'h5fffffff
`define CBM_DEV1_BASE     32'ha0000000
`define CBM_DEV2_BASE     32'hf0000000
`define CBM_SIZE_WORD     3'h2

`endif

// file: src/cbm_router.sv
// Core bus matrix router: arbitrates core and debug requests, decodes targets.
// Assumes single-cycle requests on one clock; targets answer in the issue cycle.
`timescale 1ns/1ps
`include "cbm_regs.svh"

module cbm_router (
  input  wire logic        clk_i,          // Core clock
  input  wire logic        nrst_i,         // Sync reset, active low
  input  wire logic        en_i,           // Clock enable
  input  wire logic        core_req_i,     // Core request
  input  wire logic [31:0] core_addr_i,    // Core address
  input  wire logic        core_write_i,   // Core write
  input  wire logic [2:0]  core_size_i,    // Core transfer size
  input  wire logic        core_fetch_i,   // Core instruction fetch
  input  wire logic [31:0] core_wdata_i,   // Core write data
  output logic             core_gnt_o,     // Core request taken
  output logic             core_rvalid_o,  // Core answer valid
  output logic             core_err_o,     // Core error answer
  output logic             core_hard_fault_o, // Hard fault toward core
  output logic [31:0]      core_rdata_o,   // Core read data
  input  wire logic        dbg_req_i,      // Debug port request
  input  wire logic [31:0] dbg_addr_i,     // Debug address
  input  wire logic        dbg_write_i,    // Debug write
  input  wire logic [2:0]  dbg_size_i,     // Debug transfer size
  input  wire logic [31:0] dbg_wdata_i,    // Debug write data
  output logic             dbg_gnt_o,      // Debug request taken
  output logic             dbg_rvalid_o,   // Debug answer valid
  output logic             dbg_err_o,      // Debug error answer
  output logic [31:0]      dbg_rdata_o,    // Debug read data
  input  wire logic        prot_noexec_i,  // Protection unit execute-never override
  input  wire logic        prot_en_i,      // Protection unit enabled
  output logic             ahb_valid_o,    // System bus request
  output logic [31:0]      ahb_addr_o,     // System bus address
  output logic             ahb_write_o,    // System bus write
  output logic [2:0]       ahb_size_o,     // System bus size
  output logic [31:0]      ahb_wdata_o,    // System bus write data
  input  wire logic [31:0] ahb_rdata_i,    // System bus read data
  input  wire logic        ahb_err_i,      // System bus error
  output logic             scio_valid_o,   // I/O port request
  output logic [31:0]      scio_addr_o,    // I/O port address
  output logic             scio_write_o,   // I/O port write
  output logic [31:0]      scio_wdata_o,   // I/O port write data
  input  wire logic [31:0] scio_rdata_i,   // I/O port read data
  output logic             ppb_valid_o,    // Private space request
  output logic [31:0]      ppb_addr_o,     // Private space address
  output logic             ppb_write_o,    // Private space write
  output logic [31:0]      ppb_wdata_o,    // Private space write data
  input  wire logic [31:0] ppb_rdata_i,    // Private space read data
  output cbm_pkg::cbm_tgt_t last_tgt_o     // Target of last issue
);
  import cbm_pkg::*;

  // Held debug request
  logic        dpend_r;
  logic [31:0] daddr_r;
  logic        dwrite_r;
  logic [2:0]  dsize_r;
  logic [31:0] dwdata_r;

  logic        d_req;
  logic [31:0] d_addr;
  logic        d_write;
  logic [2:0]  d_size;
  logic [31:0] d_wdata;

  always_comb begin
    d_req   = dpend_r | dbg_req_i;
    d_addr  = dpend_r ? daddr_r  : dbg_addr_i;
    d_write = dpend_r ? dwrite_r : dbg_write_i;
    d_size  = dpend_r ? dsize_r  : dbg_size_i;
    d_wdata = dpend_r ? dwdata_r : dbg_wdata_i;
  end

  // Shared decoder for both masters
  function automatic cbm_tgt_t cbm_decode(input logic [31:0] a);
    if (a >= `CBM_SCIO_BASE && a <= `CBM_SCIO_LAST)
      cbm_decode = CBM_TGT_SCIO;
    else if (a >= `CBM_PPB_BASE && a <= `CBM_PPB_LAST)
      cbm_decode = CBM_TGT_PPB;
    else
      cbm_decode = CBM_TGT_AHB;
  endfunction

  function automatic logic cbm_code_ok(input logic [31:0] a);
    cbm_code_ok = (a <= `CBM_CODE0_LAST) ||
                  (a >= `CBM_CODE1_BASE && a <= `CBM_CODE1_LAST);
  endfunction

  cbm_tgt_t core_tgt;
  cbm_tgt_t dbg_tgt;
  logic     core_narrow;
  logic     dbg_narrow;
  logic     core_noexec;
  logic     core_fault;
  logic     core_go;
  logic     dbg_go;

  always_comb begin
    core_tgt    = cbm_decode(core_addr_i);
    dbg_tgt     = cbm_decode(d_addr);
    core_narrow = (core_tgt != CBM_TGT_AHB) && (core_size_i != `CBM_SIZE_WORD);
    dbg_narrow  = (dbg_tgt != CBM_TGT_AHB) && (d_size != `CBM_SIZE_WORD);
    // Private space ignores the protection unit
    if (core_tgt == CBM_TGT_PPB)
      core_noexec = 1'b1;
    else if (prot_en_i)
      core_noexec = prot_noexec_i;
    else
      core_noexec = !cbm_code_ok(core_addr_i);
    core_fault = core_fetch_i && core_noexec;
    core_go    = core_req_i && !core_fault && !core_narrow;
    // Debug only takes a slot the core leaves on its target
    dbg_go     = d_req && !dbg_narrow &&
                 !(core_go && core_tgt == dbg_tgt);
  end

  always_comb begin
    core_gnt_o = core_req_i;
    dbg_gnt_o  = d_req && (dbg_go || dbg_narrow);
  end

  // Pending debug request
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      dpend_r  <= 1'b0;
      daddr_r  <= 32'h0;
      dwrite_r <= 1'b0;
      dsize_r  <= 3'h0;
      dwdata_r <= 32'h0;
    end else if (en_i) begin
      if (dbg_req_i && !dpend_r && !dbg_gnt_o) begin
        dpend_r  <= 1'b1;
        daddr_r  <= dbg_addr_i;
        dwrite_r <= dbg_write_i;
        dsize_r  <= dbg_size_i;
        dwdata_r <= dbg_wdata_i;
      end else if (dpend_r && dbg_gnt_o) begin
        dpend_r <= 1'b0;
      end
    end
  end

  // Issue to targets, registered
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ahb_valid_o <= 1'b0;
      scio_valid_o <= 1'b0;
      ppb_valid_o <= 1'b0;
      ahb_addr_o  <= 32'h0;
      ahb_write_o <= 1'b0;
      ahb_size_o  <= 3'h0;
      ahb_wdata_o <= 32'h0;
      scio_addr_o  <= 32'h0;
      scio_write_o <= 1'b0;
      scio_wdata_o <= 32'h0;
      ppb_addr_o  <= 32'h0;
      ppb_write_o <= 1'b0;
      ppb_wdata_o <= 32'h0;
      last_tgt_o  <= CBM_TGT_NONE;
    end else if (en_i) begin
      ahb_valid_o <= (core_go && core_tgt == CBM_TGT_AHB) ||
                     (dbg_go && dbg_tgt == CBM_TGT_AHB);
      scio_valid_o <= (core_go && core_tgt == CBM_TGT_SCIO) ||
                      (dbg_go && dbg_tgt == CBM_TGT_SCIO);
      ppb_valid_o <= (core_go && core_tgt == CBM_TGT_PPB) ||
                     (dbg_go && dbg_tgt == CBM_TGT_PPB);
      if (core_go && core_tgt == CBM_TGT_AHB) begin
        ahb_addr_o  <= core_addr_i;
        ahb_write_o <= core_write_i;
        ahb_size_o  <= core_size_i;
        ahb_wdata_o <= core_wdata_i;
      end else if (dbg_go && dbg_tgt == CBM_TGT_AHB) begin
        ahb_addr_o  <= d_addr;
        ahb_write_o <= d_write;
        ahb_size_o  <= d_size;
        ahb_wdata_o <= d_wdata;
      end
      if (core_go && core_tgt == CBM_TGT_SCIO) begin
        scio_addr_o  <= core_addr_i;
        scio_write_o <= core_write_i;
        scio_wdata_o <= core_wdata_i;
      end else if (dbg_go && dbg_tgt == CBM_TGT_SCIO) begin
        scio_addr_o  <= d_addr;
        scio_write_o <= d_write;
        scio_wdata_o <= d_wdata;
      end
      if (core_go && core_tgt == CBM_TGT_PPB) begin
        ppb_addr_o  <= core_addr_i;
        ppb_write_o <= core_write_i;
        ppb_wdata_o <= core_wdata_i;
      end else if (dbg_go && dbg_tgt == CBM_TGT_PPB) begin
        ppb_addr_o  <= d_addr;
        ppb_write_o <= d_write;
        ppb_wdata_o <= d_wdata;
      end
      if (core_go)
        last_tgt_o <= core_tgt;
      else if (dbg_go)
        last_tgt_o <= dbg_tgt;
    end
  end

  // Answer routing: remember who went where and what failed
  logic     c_busy_r;
  logic     c_bad_r;
  logic     c_hf_r;
  cbm_tgt_t c_tgt_r;
  logic     d_busy_r;
  logic     d_bad_r;
  cbm_tgt_t d_tgt_r;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      c_busy_r <= 1'b0;
      c_bad_r  <= 1'b0;
      c_hf_r   <= 1'b0;
      c_tgt_r  <= CBM_TGT_NONE;
      d_busy_r <= 1'b0;
      d_bad_r  <= 1'b0;
      d_tgt_r  <= CBM_TGT_NONE;
    end else if (en_i) begin
      c_busy_r <= core_req_i;
      c_bad_r  <= core_req_i && (core_narrow || core_fault);
      c_hf_r   <= core_req_i && core_fault;
      c_tgt_r  <= core_tgt;
      d_busy_r <= dbg_gnt_o;
      d_bad_r  <= dbg_gnt_o && dbg_narrow;
      d_tgt_r  <= dbg_tgt;
    end
  end

  function automatic logic [31:0] cbm_pick(input cbm_tgt_t t, input logic [31:0] a,
                                           input logic [31:0] s, input logic [31:0] p);
    case (t)
      CBM_TGT_AHB: cbm_pick = a;
      CBM_TGT_SCIO: cbm_pick = s;
      CBM_TGT_PPB: cbm_pick = p;
      default:     cbm_pick = 32'h0;
    endcase
  endfunction

  always_comb begin
    core_rvalid_o    = c_busy_r;
    core_hard_fault_o = c_hf_r;
    core_err_o       = c_bad_r || (c_busy_r && c_tgt_r == CBM_TGT_AHB && ahb_err_i);
    core_rdata_o     = c_bad_r ? 32'h0 : cbm_pick(c_tgt_r, ahb_rdata_i, scio_rdata_i, ppb_rdata_i);
    dbg_rvalid_o     = d_busy_r;
    dbg_err_o        = d_bad_r || (d_busy_r && d_tgt_r == CBM_TGT_AHB && ahb_err_i);
    dbg_rdata_o      = d_bad_r ? 32'h0 : cbm_pick(d_tgt_r, ahb_rdata_i, scio_rdata_i, ppb_rdata_i);
  end
endmodule

// file: tb/cbm_router_monitor.sv
// Port checks of the bus matrix router.
// Bound into every cbm_router; one clock domain.
`timescale 1ns/1ps
module cbm_router_monitor (
  input wire logic        clk_i, nrst_i, en_i, core_req_i, core_fetch_i, dbg_req_i,
  input wire logic        prot_en_i, prot_noexec_i, core_gnt_o, dbg_gnt_o, core_err_o,
  input wire logic        core_hard_fault_o, ahb_valid_o, scio_valid_o, ppb_valid_o,
  input wire logic [2:0]  core_size_i, dbg_size_i,
  input wire logic [31:0] core_addr_i, dbg_addr_i, ahb_addr_o
);
  function automatic logic [1:0] tg(input logic [31:0] a);
    return a[31:28] == 4'hd ? 2'h1 : a[31:28] == 4'he ? 2'h2 : 2'h0;
  endfunction
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence solo;
    en_i && core_req_i && !dbg_req_i && core_size_i == 3'h2 && !core_fetch_i;
  endsequence
  sequence fetch;
    en_i && core_req_i && !dbg_req_i && core_size_i == 3'h2 && core_fetch_i;
  endsequence
  a_core_wins:
    assert property (en_i && core_req_i && dbg_req_i && tg(core_addr_i) == tg(dbg_addr_i)
      |-> !dbg_gnt_o) else $error("debug beat core");
  a_no_stall:
    assert property (core_req_i |-> core_gnt_o) else $error("core stalled");
  a_sys_route:
    assert property (solo ##0 tg(core_addr_i) == 2'h0 |=> ahb_valid_o && !scio_valid_o
      && ahb_addr_o == $past(core_addr_i)) else $error("system route wrong");
  a_io_route:
    assert property (solo ##0 tg(core_addr_i) == 2'h1 |=> scio_valid_o && !ahb_valid_o)
      else $error("io route wrong");
  a_priv_route:
    assert property (solo ##0 tg(core_addr_i) == 2'h2 |=> ppb_valid_o && !ahb_valid_o)
      else $error("private route wrong");
  a_dbg_map:
    assert property (en_i && dbg_gnt_o && !core_req_i && dbg_size_i == 3'h2 &&
      tg(dbg_addr_i) == 2'h1 |=> scio_valid_o) else $error("debug map differs");
  a_narrow_err:
    assert property (en_i && core_req_i && !dbg_req_i && tg(core_addr_i) != 2'h0 &&
      core_size_i != 3'h2 |=> core_err_o && !scio_valid_o && !ppb_valid_o)
      else $error("narrow access issued");
  a_xn_fault:
    assert property (fetch ##0 !prot_en_i |=> core_hard_fault_o == !($past(core_addr_i)
      < 32'h40000000 || $past(core_addr_i) inside {[32'h60000000:32'h9fffffff]})
      && (!core_hard_fault_o || core_err_o && !ahb_valid_o)) else $error("fetch guard wrong");
  a_priv_fixed:
    assert property (fetch ##0 prot_en_i && !prot_noexec_i && tg(core_addr_i) == 2'h2
      |=> core_hard_fault_o) else $error("private space executable");
  a_dbg_wait:
    assert property (en_i && dbg_req_i && !dbg_gnt_o |-> ##[1:8] dbg_gnt_o)
      else $error("debug starved");
endmodule
bind cbm_router cbm_router_monitor mon (.*);

// file: tb/cbm_slave_model.sv
// Behavioural target standing on one issue port of the router.
// Answers in the issue cycle; between issues the data lines show the inverted read pattern.
`timescale 1ns/1ps
module cbm_slave_model #(
  parameter logic [31:0] SALT = 32'h0  // Read data is address xor this
) (
  input  wire logic        valid_i,  // Issue pulse
  input  wire logic [31:0] addr_i,   // Issued address
  output logic [31:0]      rdata_o,  // Read data
  output logic             err_o     // Error answer
);
  assign rdata_o = valid_i ? addr_i ^ SALT : ~(addr_i ^ SALT);
  // Addresses ending in bad0 answer with an error
  assign err_o = valid_i && addr_i[15:0] == 16'hbad0;
endmodule

// file: tb/core_bus_matrix_router_tb.sv
// Self-checking bench for the bus matrix router.
// Three target models answer the issue ports; the monitor is bound in.
`timescale 1ns/1ps
module core_bus_matrix_router_tb;
  import cbm_pkg::*;
  logic clk_i, nrst_i, en_i, core_req_i, core_write_i, core_fetch_i, core_gnt_o, core_rvalid_o;
  logic core_err_o, core_hard_fault_o, dbg_req_i, dbg_write_i, dbg_gnt_o, dbg_rvalid_o, dbg_err_o;
  logic prot_noexec_i, prot_en_i, ahb_valid_o, ahb_write_o, ahb_err_i, scio_valid_o, scio_write_o;
  logic ppb_valid_o, ppb_write_o;
  logic [2:0] core_size_i, dbg_size_i, ahb_size_o;
  logic [31:0] core_addr_i, core_wdata_i, core_rdata_o, dbg_addr_i, dbg_wdata_i, dbg_rdata_o;
  logic [31:0] ahb_addr_o, ahb_wdata_o, ahb_rdata_i, scio_addr_o, scio_wdata_o, scio_rdata_i;
  logic [31:0] ppb_addr_o, ppb_wdata_o, ppb_rdata_i;
  cbm_tgt_t last_tgt_o;
  int mismatches = 0;
  int checks_done = 0;
  logic [31:0] ra [6] = '{32'h20000000, 32'hcffffffc, 32'hd0000000, 32'hdffffffc,
                          32'he000ed00, 32'hf0000000};
  logic [31:0] fa [8] = '{32'h0, 32'h3ffffffc, 32'h40000000, 32'h60000000,
                          32'h9ffffffc, 32'ha0000000, 32'he0000000, 32'hf0000000};
  logic [1:0] ex [8] = '{2'b01, 2'b01, 2'b10, 2'b01, 2'b01, 2'b10, 2'b10, 2'b10};
  cbm_router dut (.*);
  cbm_slave_model #(.SALT(32'h0)) ahb_m (.valid_i(ahb_valid_o), .addr_i(ahb_addr_o),
    .rdata_o(ahb_rdata_i), .err_o(ahb_err_i));
  cbm_slave_model #(.SALT(32'h5a5a5a5a)) scio_m (.valid_i(scio_valid_o), .addr_i(scio_addr_o),
    .rdata_o(scio_rdata_i), .err_o());
  cbm_slave_model #(.SALT(32'ha5a5a5a5)) ppb_m (.valid_i(ppb_valid_o), .addr_i(ppb_addr_o),
    .rdata_o(ppb_rdata_i), .err_o());
  initial begin
    clk_i = 0;
    forever #10 clk_i = ~clk_i;
  end
  function automatic int tg(input logic [31:0] a);
    return a[31:28] == 4'hd ? 1 : a[31:28] == 4'he ? 2 : 0;
  endfunction
  function automatic logic [31:0] rd(input logic [31:0] a);
    return a ^ (tg(a) == 1 ? 32'h5a5a5a5a : tg(a) == 2 ? 32'ha5a5a5a5 : 32'h0);
  endfunction
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %0t: got %h want %h", $time, s, e);
    end
  endtask
  task end_of_test;
    $display("checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Issue at a falling edge; return at the next, in the answer cycle
  task core_op(input logic [31:0] a, input logic [2:0] sz, input logic f);
    {core_req_i, core_addr_i, core_size_i, core_fetch_i} = {1'b1, a, sz, f};
    {core_write_i, core_wdata_i} = {a[2], ~a};
    @(negedge clk_i);
    core_req_i = 0;
  endtask
  task dbg_op(input logic [31:0] a);
    int n;
    {dbg_req_i, dbg_addr_i, dbg_size_i, dbg_write_i, dbg_wdata_i} = {1'b1, a, 3'h2, a[2], a};
    n = 0;
    #1;
    while (dbg_gnt_o !== 1'b1 && n < 8) begin
      @(negedge clk_i);
      #1;
      n++;
    end
    @(negedge clk_i);
    dbg_req_i = 0;
  endtask
  task t_route;
    foreach (ra[i]) begin
      core_op(ra[i], 3'h2, 1'b0);
      chk({ahb_valid_o, scio_valid_o, ppb_valid_o}, 3'b100 >> tg(ra[i]));
      chk({core_rdata_o, last_tgt_o}, {rd(ra[i]), 2'(tg(ra[i]))});
      chk({core_rvalid_o, core_err_o, core_hard_fault_o}, 3'b100);
      chk(tg(ra[i]) == 0 ? ahb_wdata_o : tg(ra[i]) == 1 ? scio_wdata_o : ppb_wdata_o,
          ~ra[i]);
      dbg_op(ra[i]);
      chk({ahb_valid_o, scio_valid_o, ppb_valid_o}, 3'b100 >> tg(ra[i]));
      chk(dbg_rdata_o, rd(ra[i]));
      chk({dbg_rvalid_o, dbg_err_o}, 2'b10);
    end
    core_op(32'h1000bad0, 3'h2, 1'b0);
    chk({core_err_o, ahb_valid_o}, 2'b11);
    chk({ahb_write_o, ahb_size_o, ahb_addr_o}, {1'b0, 3'h2, 32'h1000bad0});
  endtask
  task t_narrow;
    for (int s = 0; s < 2; s++) begin
      core_op(32'hd0000000, 3'(s), 1'b0);
      chk({core_err_o, scio_valid_o}, 2'b10);
      core_op(32'he000ed00, 3'(s), 1'b0);
      chk({core_err_o, ppb_valid_o}, 2'b10);
    end
  endtask
  task t_fetch;
    foreach (fa[i]) begin
      core_op(fa[i], 3'h2, 1'b1);
      chk({core_hard_fault_o, ahb_valid_o}, ex[i]);
    end
    prot_en_i = 1;
    core_op(32'h40000000, 3'h2, 1'b1);
    chk(core_hard_fault_o, 0);
    core_op(32'he0000000, 3'h2, 1'b1);
    chk(core_hard_fault_o, 1);
    {prot_en_i, prot_noexec_i} = 0;
  endtask
  task t_clash;
    {core_req_i, core_addr_i, core_size_i, core_fetch_i} = {1'b1, 32'h20000000, 3'h2, 1'b0};
    {dbg_req_i, dbg_addr_i, dbg_size_i} = {1'b1, 32'h20000100, 3'h2};
    #1 chk({core_gnt_o, dbg_gnt_o}, 2'b10);
    @(negedge clk_i);
    core_addr_i = 32'h20000004;
    #1 chk({dbg_gnt_o, ahb_addr_o}, {1'b0, 32'h20000000});
    @(negedge clk_i);
    core_req_i = 0;
    #1 chk(dbg_gnt_o, 1);
    @(negedge clk_i);
    dbg_req_i = 0;
    chk({dbg_rvalid_o, dbg_rdata_o}, {1'b1, 32'h20000100});
    {core_req_i, core_addr_i, dbg_req_i, dbg_addr_i} = {1'b1, 32'hd0000000, 1'b1, 32'h30000000};
    @(negedge clk_i);
    {core_req_i, dbg_req_i} = 0;
    chk({scio_valid_o, ahb_valid_o, dbg_rvalid_o, core_rvalid_o}, 4'hf);
    // Clock enable low: nothing new is issued
    en_i = 0;
    core_op(32'h20000040, 3'h2, 1'b0);
    chk(ahb_addr_o, 32'h30000000);
    en_i = 1;
  endtask
  initial begin
    {core_addr_i, core_wdata_i, dbg_addr_i, dbg_wdata_i, core_size_i, dbg_size_i} = 0;
    {nrst_i, core_req_i, core_write_i, core_fetch_i, dbg_req_i, dbg_write_i} = 0;
    {prot_noexec_i, prot_en_i, en_i} = 3'b001;
    repeat (2) @(negedge clk_i);
    nrst_i = 1;
    chk({ahb_valid_o, last_tgt_o}, {1'b0, CBM_TGT_NONE});
    t_route;
    $display("route test done");
    t_narrow;
    $display("narrow test done");
    t_fetch;
    $display("fetch test done");
    t_clash;
    $display("clash test done");
    end_of_test;
  end
  initial begin
    #20000;
    mismatches++;
    end_of_test;
  end
endmodule
